/* rtl/smt_pkg.sv */
// What this block does
// - master bit rate is one third of overflow rate
// - scl high phase twice the low phase
// - scl phases never below one overflow period
// - standard mode: hold 3 clocks, setup low minus 3
// - extended mode: setup 11 clocks, hold 12 clocks
// - setup applies to ack and data bits
// - scl low timeout: reload timer while scl high
// - bus free after over 10 idle periods
// - enabled interface monitors both lines continuously
// - slave inhibit blocks slave interrupts only
// - busy set in transfer, cleared by stop/timeout
// - two-bit select picks one of four overflows
// - pending start fires after free timeout
// - split timer: only high half reloads
package smt_pkg;
    localparam logic [7:0] CFG_ADDR = 8'hc1;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int CFG_ENABLE_BIT = 7;
    localparam int CFG_INHIBIT_BIT = 6;
    localparam int CFG_BUSY_BIT = 5;
    localparam int CFG_EXTEND_BIT = 4;
    localparam int CFG_TOE_BIT = 3;
    localparam int CFG_FTE_BIT = 2;
    localparam int CFG_SRC_HI = 1;
    localparam int CFG_SRC_LO = 0;

    localparam logic [1:0] SRC_TMR0 = 2'h0;
    localparam logic [1:0] SRC_TMR1 = 2'h1;
    localparam logic [1:0] SRC_TMR2_HI = 2'h2;
    localparam logic [1:0] SRC_TMR2_LO = 2'h3;

    // overflow periods per scl phase and bus free idle time
    localparam logic [1:0] START_OVF = 2'h1;
    localparam logic [1:0] LOW_OVF = 2'h1;
    localparam logic [1:0] HIGH_OVF = 2'h2;
    localparam logic [3:0] FREE_OVF = 4'ha;

    // sda timing in core clocks
    localparam logic [3:0] HOLD_STD = 4'h3;
    localparam logic [3:0] HOLD_EXT = 4'hc;
    localparam logic [3:0] SETUP_STD = 4'h1;
    localparam logic [3:0] SETUP_EXT = 4'hb;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_START = 5'b00010,
        ST_LOW = 5'b00100,
        ST_HIGH = 5'b01000,
        ST_STOP = 5'b10000
    } smt_state_t;
endpackage : smt_pkg

/* rtl/smt_top.sv */
module smt_top import smt_pkg::*; (
    input wire logic clock_i,            // core clock, 125 MHz
    input wire logic resetn_i,           // synchronous reset, active low
    input wire logic [7:0] sfr_addr_i,   // register address
    input wire logic sfr_wr_i,           // register write strobe
    input wire logic [7:0] sfr_wdata_i,  // register write data
    output logic [7:0] sfr_rdata_o,      // register read data, one cycle later
    input wire logic tmr0_ovf_i,         // timer 0 overflow strobe
    input wire logic tmr1_ovf_i,         // timer 1 overflow strobe
    input wire logic tmr2_hi_ovf_i,      // timer 2 high byte overflow strobe
    input wire logic tmr2_lo_ovf_i,      // timer 2 low byte overflow strobe
    input wire logic tmr3_split_i,       // timeout timer runs as two halves
    output logic tmr3_hi_reload_o,       // hold timeout timer high half in reload
    output logic tmr3_lo_reload_o,       // hold timeout timer low half in reload
    input wire logic scl_i,              // scl pin level
    output logic scl_o,                  // scl drive value, always low
    output logic scl_oe_o,               // scl pulled low when high
    input wire logic sda_i,              // sda pin level
    output logic sda_o,                  // sda drive value, always low
    output logic sda_oe_o,               // sda pulled low when high
    input wire logic start_req_i,        // master start pending, level
    input wire logic bit_valid_i,        // next bit to send is ready
    input wire logic bit_data_i,         // next bit value
    input wire logic stop_req_i,         // send stop instead of a bit
    output logic bit_take_o,             // bit taken, pulse
    output logic bit_done_o,             // bit clocked out, pulse
    output logic bit_rx_o,               // sda sampled at scl high
    output logic start_done_o,           // start generated, pulse
    output logic stop_done_o,            // stop generated, pulse
    input wire logic slave_event_i,      // slave engine event
    input wire logic master_event_i,     // master engine event
    output logic slave_irq_o,            // gated slave interrupt
    output logic master_irq_o            // master interrupt
);
    logic [7:0] cfg_ff;
    logic busy_ff;
    logic scl_s1_ff, scl_s2_ff, scl_q_ff;
    logic sda_s1_ff, sda_s2_ff, sda_q_ff;
    smt_state_t state_ff;
    logic [1:0] ocnt_ff;
    logic [3:0] lcnt_ff, scnt_ff, fcnt_ff;
    logic dat_ok_ff, stop_pend_ff, hi_seen_ff, inh_act_ff;
    logic ovf, en, both_high, start_det, stop_det, free_to;
    logic [3:0] hold_c, setup_c;

    assign en = cfg_ff[CFG_ENABLE_BIT];

    always_comb begin
        unique case (cfg_ff[CFG_SRC_HI:CFG_SRC_LO])
            SRC_TMR0: ovf = tmr0_ovf_i;
            SRC_TMR1: ovf = tmr1_ovf_i;
            SRC_TMR2_HI: ovf = tmr2_hi_ovf_i;
            SRC_TMR2_LO: ovf = tmr2_lo_ovf_i;
        endcase
    end

    assign hold_c = cfg_ff[CFG_EXTEND_BIT] ? HOLD_EXT : HOLD_STD;
    assign setup_c = cfg_ff[CFG_EXTEND_BIT] ? SETUP_EXT : SETUP_STD;

    // pins are asynchronous: two flops before anything looks at them
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_q_ff <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_s1_ff <= scl_i;
            scl_s2_ff <= scl_s1_ff;
            scl_q_ff <= scl_s2_ff;
            sda_s1_ff <= sda_i;
            sda_s2_ff <= sda_s1_ff;
            sda_q_ff <= sda_s2_ff;
        end
    end

    assign both_high = scl_s2_ff & sda_s2_ff;
    assign start_det = en & scl_s2_ff & scl_q_ff & sda_q_ff & ~sda_s2_ff;
    assign stop_det = en & scl_s2_ff & scl_q_ff & ~sda_q_ff & sda_s2_ff;
    assign free_to = en & cfg_ff[CFG_FTE_BIT] & both_high & ovf & (fcnt_ff == FREE_OVF);

    // idle-time counter saturates one past the limit so the timeout fires once
    always_ff @(posedge clock_i) begin
        if (!resetn_i || !both_high || !en) begin
            fcnt_ff <= 4'h0;
        end else if (ovf && fcnt_ff != FREE_OVF + 4'h1) begin
            fcnt_ff <= fcnt_ff + 4'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i || !en) begin
            busy_ff <= 1'b0;
        end else if (start_det || state_ff != ST_IDLE) begin
            // set wins: an own transfer in flight keeps the bus busy even if a stop is seen
            busy_ff <= 1'b1;
        end else if (stop_det || free_to) begin
            busy_ff <= 1'b0;
        end
    end

    // busy bit is hardware-owned; writes to it are dropped
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            cfg_ff <= CFG_RESET;
        end else if (sfr_wr_i && sfr_addr_i == CFG_ADDR) begin
            cfg_ff <= sfr_wdata_i & ~(8'h01 << CFG_BUSY_BIT);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_addr_i == CFG_ADDR) begin
            sfr_rdata_o <= cfg_ff | ({7'h00, busy_ff} << CFG_BUSY_BIT);
        end else begin
            sfr_rdata_o <= 8'h00;
        end
    end

    // timeout timer counts only while scl is low
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            tmr3_hi_reload_o <= 1'b0;
            tmr3_lo_reload_o <= 1'b0;
        end else begin
            tmr3_hi_reload_o <= en & cfg_ff[CFG_TOE_BIT] & scl_s2_ff;
            tmr3_lo_reload_o <= en & cfg_ff[CFG_TOE_BIT] & scl_s2_ff & ~tmr3_split_i;
        end
    end

    // inhibit takes hold at the next start so the current transfer finishes
    always_ff @(posedge clock_i) begin
        if (!resetn_i || !en) begin
            inh_act_ff <= 1'b0;
        end else if (start_det) begin
            inh_act_ff <= cfg_ff[CFG_INHIBIT_BIT];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            slave_irq_o <= 1'b0;
            master_irq_o <= 1'b0;
        end else begin
            slave_irq_o <= en & slave_event_i & ~inh_act_ff;
            master_irq_o <= en & master_event_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

    // master scl/sda sequencer
    always_ff @(posedge clock_i) begin
        if (!resetn_i || !en) begin
            state_ff <= ST_IDLE;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
            ocnt_ff <= 2'h0;
            lcnt_ff <= 4'h0;
            scnt_ff <= 4'h0;
            dat_ok_ff <= 1'b0;
            stop_pend_ff <= 1'b0;
            hi_seen_ff <= 1'b0;
            bit_take_o <= 1'b0;
            bit_done_o <= 1'b0;
            bit_rx_o <= 1'b0;
            start_done_o <= 1'b0;
            stop_done_o <= 1'b0;
        end else begin
            bit_take_o <= 1'b0;
            bit_done_o <= 1'b0;
            start_done_o <= 1'b0;
            stop_done_o <= 1'b0;
            unique case (state_ff)
                ST_IDLE: begin
                    scl_oe_o <= 1'b0;
                    sda_oe_o <= 1'b0;
                    ocnt_ff <= 2'h0;
                    if (start_req_i && !busy_ff) begin
                        sda_oe_o <= 1'b1;
                        state_ff <= ST_START;
                    end
                end
                ST_START: begin
                    if (ovf && ocnt_ff == START_OVF - 2'h1) begin
                        scl_oe_o <= 1'b1;
                        state_ff <= ST_LOW;
                        ocnt_ff <= 2'h0;
                        lcnt_ff <= 4'h0;
                        dat_ok_ff <= 1'b0;
                        start_done_o <= 1'b1;
                    end else if (ovf) begin
                        ocnt_ff <= ocnt_ff + 2'h1;
                    end
                end
                ST_LOW: begin
                    if (ovf && ocnt_ff != 2'h3) begin
                        ocnt_ff <= ocnt_ff + 2'h1;
                    end
                    if (lcnt_ff != 4'hf) begin
                        lcnt_ff <= lcnt_ff + 4'h1;
                    end
                    if (!dat_ok_ff && lcnt_ff >= hold_c - 4'h1) begin
                        // late data keeps scl low: setup is then setup_c clocks counted from the data change
                        if (bit_valid_i) begin
                            sda_oe_o <= ~bit_data_i;
                            dat_ok_ff <= 1'b1;
                            scnt_ff <= 4'h0;
                            stop_pend_ff <= 1'b0;
                            bit_take_o <= 1'b1;
                        end else if (stop_req_i) begin
                            sda_oe_o <= 1'b1;
                            dat_ok_ff <= 1'b1;
                            scnt_ff <= 4'h0;
                            stop_pend_ff <= 1'b1;
                        end
                    end
                    if (dat_ok_ff) begin
                        if (scnt_ff != 4'hf) begin
                            scnt_ff <= scnt_ff + 4'h1;
                        end
                        if (ocnt_ff >= LOW_OVF && scnt_ff >= setup_c - 4'h1) begin
                            scl_oe_o <= 1'b0;
                            ocnt_ff <= 2'h0;
                            hi_seen_ff <= 1'b0;
                            state_ff <= stop_pend_ff ? ST_STOP : ST_HIGH;
                        end
                    end
                end
                ST_HIGH: begin
                    // high time counts from when scl is really seen high, so stretching is honoured
                    if (!hi_seen_ff) begin
                        if (scl_s2_ff) begin
                            hi_seen_ff <= 1'b1;
                            bit_rx_o <= sda_s2_ff;
                        end
                    end else if (!scl_s2_ff || (ovf && ocnt_ff == HIGH_OVF - 2'h1)) begin
                        scl_oe_o <= 1'b1;
                        state_ff <= ST_LOW;
                        ocnt_ff <= 2'h0;
                        lcnt_ff <= 4'h0;
                        dat_ok_ff <= 1'b0;
                        bit_done_o <= 1'b1;
                    end else if (ovf) begin
                        ocnt_ff <= ocnt_ff + 2'h1;
                    end
                end
                ST_STOP: begin
                    if (!hi_seen_ff) begin
                        hi_seen_ff <= scl_s2_ff;
                    end else if (ovf) begin
                        sda_oe_o <= 1'b0;
                        stop_pend_ff <= 1'b0;
                        state_ff <= ST_IDLE;
                        stop_done_o <= 1'b1;
                    end
                end
            endcase
        end
    end
endmodule : smt_top

/* dv/smt_top_assertions.sv */
module smt_top_assertions import smt_pkg::*; (
    input wire logic clock_i, // core clock
    input wire logic resetn_i, // sync reset
    input wire logic [7:0] sfr_addr_i, // address
    input wire logic sfr_wr_i, // write strobe
    input wire logic [7:0] sfr_wdata_i, // write data
    input wire logic scl_i, // scl pin
    input wire logic scl_oe_o, // scl pull
    input wire logic sda_oe_o, // sda pull
    input wire logic tmr3_split_i, // split timer
    input wire logic tmr3_hi_reload_o, // high reload
    input wire logic tmr3_lo_reload_o, // low reload
    input wire logic slave_event_i, // slave event
    input wire logic master_event_i, // master event
    input wire logic slave_irq_o, // slave irq
    input wire logic master_irq_o, // master irq
    input wire logic start_done_o, // start pulse
    input wire logic bit_done_o, // bit pulse
    input wire logic stop_done_o // stop pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    chk_disable_idle: assert property (
        sfr_wr_i && sfr_addr_i == CFG_ADDR && !sfr_wdata_i[CFG_ENABLE_BIT] |-> ##2 !scl_oe_o && !sda_oe_o)
        else $error("lines held after disable");
    chk_reload_scl: assert property (
        !scl_i [*5] |=> !tmr3_hi_reload_o) else $error("reload while scl low");
    chk_split_half: assert property (
        tmr3_lo_reload_o |-> tmr3_hi_reload_o && !$past(tmr3_split_i)) else $error("low half reloaded");
    chk_slave_gate: assert property (
        slave_irq_o |-> $past(slave_event_i)) else $error("slave irq without event");
    chk_master_irq: assert property (
        master_irq_o |-> $past(master_event_i)) else $error("master irq without event");
    chk_sda_hold: assert property (
        $rose(scl_oe_o) |=> $stable(sda_oe_o) [*2]) else $error("sda hold too short");
    chk_setup_edge: assert property (
        $changed(sda_oe_o) && $past(scl_oe_o) |-> scl_oe_o) else $error("sda and scl moved together");
    chk_start_order: assert property (
        start_done_o |-> scl_oe_o && sda_oe_o && $past(sda_oe_o)) else $error("start shape wrong");
    chk_bit_end: assert property (
        bit_done_o |-> scl_oe_o && !$past(scl_oe_o)) else $error("bit end without scl pull");
    cover property (start_done_o);
    cover property (stop_done_o);
    cover property (tmr3_lo_reload_o);
endmodule : smt_top_assertions

/* dv/smt_bus_model.sv */
module smt_bus_model (
    input wire logic scl_oe_i, // device pulls scl
    input wire logic sda_oe_i, // device pulls sda
    input wire logic stretch_i, // slave holds scl low
    input wire logic sda_pull_i, // other master pulls sda
    output logic scl_o, // scl wire
    output logic sda_o // sda wire
);
    timeunit 1ns;
    timeprecision 1ns;
    // pull-ups: a released line reads high, never the last driven value
    assign scl_o = !(scl_oe_i || stretch_i);
    assign sda_o = !(sda_oe_i || sda_pull_i);
endmodule : smt_bus_model

/* dv/tb.sv */
module tb import smt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i, resetn_i, sfr_wr_i, tmr3_split_i, start_req_i, bit_valid_i, bit_data_i, stop_req_i;
    logic slave_event_i, master_event_i, stretch, sda_pull, scl, sda, scl_q, sda_q;
    logic scl_oe_o, sda_oe_o, hi_rl, lo_rl, bit_take_o, bit_done_o, bit_rx_o, start_done_o, stop_done_o;
    logic s_irq, m_irq, scl_d, sda_d;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
    logic [3:0] ovf;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int t_rise, t_fall, t_chg, t_done, hold, setup, per, high, t0;
    int ovf_per [4] = '{8, 10, 12, 14};

    smt_top uut (.clock_i, .resetn_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o,
        .tmr0_ovf_i(ovf[0]), .tmr1_ovf_i(ovf[1]), .tmr2_hi_ovf_i(ovf[2]), .tmr2_lo_ovf_i(ovf[3]),
        .tmr3_split_i, .tmr3_hi_reload_o(hi_rl), .tmr3_lo_reload_o(lo_rl), .scl_i(scl), .scl_o(scl_d),
        .scl_oe_o, .sda_i(sda), .sda_o(sda_d), .sda_oe_o, .start_req_i, .bit_valid_i, .bit_data_i,
        .stop_req_i, .bit_take_o, .bit_done_o, .bit_rx_o, .start_done_o, .stop_done_o,
        .slave_event_i, .master_event_i, .slave_irq_o(s_irq), .master_irq_o(m_irq));
    smt_bus_model bus (.scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o), .stretch_i(stretch),
        .sda_pull_i(sda_pull), .scl_o(scl), .sda_o(sda));

    initial begin
        clock_i = 0;
        forever #4 clock_i = ~clock_i;
    end
    // distinct periods let the measured bit time identify the chosen source
    always @(negedge clock_i)
        for (int i = 0; i < 4; i++)
            ovf[i] = (cyc % ovf_per[i]) == 0;
    always @(posedge clock_i) begin
        cyc++;
        if (scl_oe_o && !scl_q)
            t_rise = cyc;
        if (!scl_oe_o && scl_q) begin
            t_fall = cyc;
            setup = cyc - t_chg;
        end
        if (sda_oe_o !== sda_q) begin
            t_chg = cyc;
            hold = cyc - t_rise;
        end
        if (bit_done_o) begin
            per = cyc - t_done;
            t_done = cyc;
            high = cyc - t_fall;
        end
        scl_q = scl_oe_o;
        sda_q = sda_oe_o;
    end

    task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic end_sim;
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic wait_hi(ref logic s);
        int n = 0;
        while (s !== 1'b1 && n < 2000) begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 2000)
            cmp("handshake", 1, 0);
        @(negedge clock_i);
    endtask : wait_hi
    task automatic wr(logic [7:0] a, logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1;
        @(negedge clock_i);
        sfr_wr_i = 0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        sfr_addr_i = a;
        @(negedge clock_i);
        cmp("cfg read", exp, sfr_rdata_o);
    endtask : rd
    task automatic frame(logic [7:0] cfg, int p, logic st);
        wr(CFG_ADDR, cfg);
        start_req_i = 1;
        wait_hi(start_done_o);
        start_req_i = 0;
        for (int i = 0; i < 3; i++) begin
            bit_valid_i = 1;
            bit_data_i = !i[0];
            wait_hi(bit_take_o);
            bit_valid_i = 0;
            stretch = st && i == 1;
            if (stretch) begin
                repeat (60) @(negedge clock_i);
                cmp("reload stretched", 0, hi_rl);
                stretch = 0;
            end
            wait_hi(bit_done_o);
            cmp("rx", !i[0], bit_rx_o);
            cmp("hold", 1, hold >= (cfg[CFG_EXTEND_BIT] ? 12 : 3));
            cmp("setup", 1, setup >= (cfg[CFG_EXTEND_BIT] ? 11 : 1));
            if (st && i == 1)
                cmp("stretch", 1, high >= 60);
            if (p > 0 && i > 0) begin
                cmp("period", 1, per >= 3 * p - 1 && per <= 3 * p + 1);
                cmp("high", 1, high >= 2 * p - 1 && high <= 2 * p + 1);
            end
        end
        rd(CFG_ADDR, cfg | 8'h20);
        stop_req_i = 1;
        wait_hi(stop_done_o);
        stop_req_i = 0;
        repeat (4) @(negedge clock_i);
        rd(CFG_ADDR, cfg);
    endtask : frame

    initial begin
        {sfr_wr_i, tmr3_split_i, start_req_i, bit_valid_i, bit_data_i, stop_req_i, ovf} = '0;
        {slave_event_i, master_event_i, stretch, sda_pull, scl_q, sda_q} = '0;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        resetn_i = 0;
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        resetn_i = 1;
        rd(CFG_ADDR, CFG_RESET);
        rd(8'h55, 8'h00);
        wr(8'h55, 8'hff);
        rd(CFG_ADDR, 8'h00);
        wr(CFG_ADDR, 8'hff);
        rd(CFG_ADDR, 8'hdf);
        for (int s = 0; s < 4; s++)
            frame({6'h20, s[1:0]}, ovf_per[s], 0);
        // standard hold is only 24 ns at this clock, so extension is chosen for the first of these two frames
        frame(8'h90, 0, 0);
        frame(8'h88, 0, 1);
        cmp("reload hi", 1, hi_rl);
        cmp("reload lo", 1, lo_rl);
        cmp("pin drive", 8'h00, {6'h00, scl_d, sda_d});
        tmr3_split_i = 1;
        @(negedge clock_i);
        cmp("split hi", 1, hi_rl);
        cmp("split lo", 0, lo_rl);
        tmr3_split_i = 0;
        wr(CFG_ADDR, 8'h84);
        slave_event_i = 1;
        master_event_i = 1;
        @(negedge clock_i);
        cmp("slave irq", 1, s_irq);
        wr(CFG_ADDR, 8'hc4);
        // other master starts, then leaves the bus without a stop: only the free timeout clears busy
        sda_pull = 1;
        repeat (5) @(negedge clock_i);
        stretch = 1;
        repeat (5) @(negedge clock_i);
        sda_pull = 0;
        repeat (5) @(negedge clock_i);
        stretch = 0;
        t0 = cyc;
        start_req_i = 1;
        rd(CFG_ADDR, 8'he4);
        wait_hi(start_done_o);
        start_req_i = 0;
        cmp("free wait", 1, cyc - t0 >= 80 && cyc - t0 <= 110);
        cmp("inhibited", 0, s_irq);
        cmp("master irq", 1, m_irq);
        slave_event_i = 0;
        master_event_i = 0;
        bit_valid_i = 1;
        bit_data_i = 1;
        wait_hi(bit_take_o);
        bit_valid_i = 0;
        wr(CFG_ADDR, 8'h00);
        @(negedge clock_i);
        cmp("scl free", 0, scl_oe_o);
        cmp("sda free", 0, sda_oe_o);
        rd(CFG_ADDR, 8'h00);
        frame(8'h80, 8, 0);
        end_sim;
    end
    initial begin
        #200000;
        n_errors++;
        end_sim;
    end
endmodule : tb

bind smt_top smt_top_assertions chk (.clock_i, .resetn_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .scl_i,
    .scl_oe_o, .sda_oe_o, .tmr3_split_i, .tmr3_hi_reload_o, .tmr3_lo_reload_o, .slave_event_i,
    .master_event_i, .slave_irq_o, .master_irq_o, .start_done_o, .bit_done_o, .stop_done_o);
